//--- verilog/awc_map.svh
// Register offsets, field positions, reset values and timing counts.
`ifndef AWC_MAP_SVH
`define AWC_MAP_SVH
`define AWC_OFF_CTRL       8'h00
`define AWC_OFF_SAR_DIV    8'h04
`define AWC_OFF_RES_HIGH   8'h08
`define AWC_OFF_RES_LOW    8'h0c
`define AWC_OFF_GT_HIGH    8'h10
`define AWC_OFF_GT_LOW     8'h14
`define AWC_OFF_LT_HIGH    8'h18
`define AWC_OFF_LT_LOW     8'h1c
`define AWC_OFF_IRQ_STAT   8'h20
`define AWC_OFF_IRQ_MASK   8'h24
`define AWC_CTRL_START     0
`define AWC_CTRL_BUSY      1
`define AWC_CTRL_LEFT      2
`define AWC_CTRL_WIN       3
`define AWC_RST_GT         16'hffff
`define AWC_RST_LT         16'h0000
`define AWC_RST_SAR_DIV    8'h00
`define AWC_SAR_CYCLES     4'hd
`define AWC_CODE_BITS      12
`define AWC_RESP_OKAY      2'h0
`define AWC_RESP_SLVERR    2'h2
`endif

//--- verilog/awc_pkg.sv
// Types shared by the window comparator and its conversion sequencer.
`default_nettype none
package awc_pkg;
   typedef enum logic [3:0] {
      st_idle   = 4'h1,
      st_start  = 4'h2,
      st_sar    = 4'h4,
      st_finish = 4'h8
   } awc_conv_e;
   typedef struct packed {
      awc_conv_e   state;
      logic [11:0] sync1;
      logic [11:0] sync2;
      logic [3:0]  bits;
      logic [7:0]  div_cnt;
      logic [11:0] code;
      logic        done;
   } awc_conv_s;
   typedef struct packed {
      logic [7:0]  aw_addr;
      logic        aw_got;
      logic [7:0]  w_data;
      logic        w_lane0;
      logic        w_got;
      logic        bvalid;
      logic [1:0]  bresp;
      logic        rvalid;
      logic [31:0] rdata;
      logic [1:0]  rresp;
      logic        start;
      logic        left_just;
      logic        win_flag;
      logic [7:0]  sar_div;
      logic [11:0] raw_code;
      logic [15:0] gt;
      logic [15:0] lt;
      logic        irq_stat;
      logic        irq_mask;
   } awc_regs_s;
endpackage
`default_nettype wire

//--- verilog/awc_conv_if.sv
// Link between the register block and the conversion sequencer.
`timescale 1ns/1ps
`default_nettype none
interface awc_conv_if;
   logic        start;
   logic [7:0]  div;
   logic        busy;
   logic        done;
   logic [11:0] code;
   modport ctl (output start, output div, input busy, input done,
                input code);
   modport cnv (input start, input div, output busy, output done,
                output code);
endinterface
`default_nettype wire

//--- verilog/awc_conv.sv
// Conversion sequencer: start cycle, thirteen SAR clocks, finish cycle.
`timescale 1ns/1ps
`default_nettype none
`include "awc_map.svh"
module awc_conv (
   // Clock, reset and enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Code from the analog front end
   input  wire logic [11:0] sample_code,
   // Control side
   awc_conv_if.cnv          cif
);
   awc_pkg::awc_conv_s s_q;
   awc_pkg::awc_conv_s s_d;

   assign cif.busy = (s_q.state != awc_pkg::st_idle);
   assign cif.done = s_q.done;
   assign cif.code = s_q.code;

   always_comb begin
      s_d       = s_q;
      s_d.done  = 1'b0;
      s_d.sync1 = sample_code;
      s_d.sync2 = s_q.sync1;
      case (s_q.state)
         awc_pkg::st_idle: begin
            if (cif.start) begin
               s_d.state = awc_pkg::st_start;
            end
         end
         awc_pkg::st_start: begin
            s_d.state   = awc_pkg::st_sar;
            s_d.bits    = `AWC_SAR_CYCLES;
            s_d.div_cnt = cif.div;
         end
         awc_pkg::st_sar: begin
            if (s_q.div_cnt == 8'h00) begin
               s_d.div_cnt = cif.div;
               s_d.bits    = s_q.bits - 4'h1;
               if (s_q.bits == 4'h1) begin
                  s_d.state = awc_pkg::st_finish;
               end
            end else begin
               s_d.div_cnt = s_q.div_cnt - 8'h01;
            end
         end
         awc_pkg::st_finish: begin
            s_d.code  = s_q.sync2;
            s_d.done  = 1'b1;
            s_d.state = awc_pkg::st_idle;
         end
         default: begin
            s_d.state = awc_pkg::st_idle;
         end
      endcase
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         s_q <= '{state: awc_pkg::st_idle, default: '0};
      end else if (ce) begin
         s_q <= s_d;
      end
   end
endmodule // awc_conv
`default_nettype wire

//--- verilog/awc_top.sv
// Window comparator on the converter result with its AXI4-Lite registers.
//
// Contract
// - Every new conversion result is compared with the two bounds and the window flag is set when the condition holds.
// - The window flag can be polled and also raises the interrupt.
// - A greater-than bound and a less-than bound are each built from a high byte and a low byte register.
// - With less-than above greater-than the flag sets only for results strictly between them.
// - Otherwise the flag sets for results strictly below the lower or strictly above the upper bound.
// - Inside or outside detection follows only from the order of the two bounds.
// - Results are 12-bit unsigned codes, 0 to 4095.
// - The comparison uses the result in the justification currently selected.
// - A conversion takes 13 SAR clocks plus 2 system clocks before its result is compared.
`timescale 1ns/1ps
`default_nettype none
`include "awc_map.svh"
module awc_top (
   // Clock, reset and enable
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic        ce,
   // Converter front end
   input  wire logic [11:0] sample_code,
   // AXI4-Lite write address
   input  wire logic [7:0]  s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   // AXI4-Lite write data
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // AXI4-Lite read address
   input  wire logic [7:0]  s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   // AXI4-Lite read data
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Interrupt
   output logic             irq
);
   awc_pkg::awc_regs_s r_q;
   awc_pkg::awc_regs_s r_d;
   awc_conv_if         cif ();

   logic [15:0] result_word;
   logic [15:0] new_word;
   logic        inside_mode;
   logic        window_hit;
   logic        do_write;
   logic        do_read;
   logic        wr_ctrl;
   logic        flag_clear;

   awc_conv u_conv (
      .aclk        (aclk),
      .aresetn     (aresetn),
      .ce          (ce),
      .sample_code (sample_code),
      .cif         (cif.cnv)
   );

   assign cif.start = r_q.start;
   assign cif.div   = r_q.sar_div;

   // Handshake outputs come straight from the channel state.
   assign s_axi_awready = !r_q.aw_got;
   assign s_axi_wready  = !r_q.w_got;
   assign s_axi_arready = !r_q.rvalid;
   assign s_axi_bvalid  = r_q.bvalid;
   assign s_axi_bresp   = r_q.bresp;
   assign s_axi_rvalid  = r_q.rvalid;
   assign s_axi_rdata   = r_q.rdata;
   assign s_axi_rresp   = r_q.rresp;

   // The same flag drives the line and is readable when masked.
   assign irq = r_q.irq_stat & r_q.irq_mask;

   // Places a 12-bit code in the selected justification.
   function automatic logic [15:0] justify(
      input logic [11:0] code,
      input logic        left
   );
      logic [15:0] w;
      if (left) begin
         w = {code, 4'h0};
      end else begin
         w = {4'h0, code};
      end
      return w;
   endfunction

   // Reads follow the live justification bit, so a change of
   // justification shows at once on the stored result.
   assign result_word = justify(r_q.raw_code, r_q.left_just);
   assign new_word    = justify(cif.code, r_q.left_just);

   // No mode bit exists: the order of the bounds picks the test.
   assign inside_mode = (r_q.lt > r_q.gt);

   always_comb begin
      if (inside_mode) begin
         window_hit = (new_word > r_q.gt) && (new_word < r_q.lt);
      end else begin
         window_hit = (new_word < r_q.lt) || (new_word > r_q.gt);
      end
   end

   assign do_write = r_q.aw_got && r_q.w_got && !r_q.bvalid;
   assign do_read  = s_axi_arvalid && !r_q.rvalid;
   assign wr_ctrl  = do_write && r_q.w_lane0
                     && (r_q.aw_addr == `AWC_OFF_CTRL);
   assign flag_clear = wr_ctrl && !r_q.w_data[`AWC_CTRL_WIN];

   always_comb begin
      r_d       = r_q;
      r_d.start = 1'b0;

      // Address and data are taken in either order and held.
      if (s_axi_awvalid && !r_q.aw_got) begin
         r_d.aw_addr = s_axi_awaddr;
         r_d.aw_got  = 1'b1;
      end
      if (s_axi_wvalid && !r_q.w_got) begin
         r_d.w_data  = s_axi_wdata[7:0];
         r_d.w_lane0 = s_axi_wstrb[0];
         r_d.w_got   = 1'b1;
      end

      if (do_write) begin
         r_d.aw_got = 1'b0;
         r_d.w_got  = 1'b0;
         r_d.bvalid = 1'b1;
         r_d.bresp  = `AWC_RESP_OKAY;
         case (r_q.aw_addr)
            `AWC_OFF_CTRL: begin
               if (r_q.w_lane0) begin
                  r_d.left_just = r_q.w_data[`AWC_CTRL_LEFT];
                  r_d.start     = r_q.w_data[`AWC_CTRL_START]
                                  && !cif.busy;
               end
            end
            `AWC_OFF_SAR_DIV: begin
               if (r_q.w_lane0) begin
                  r_d.sar_div = r_q.w_data;
               end
            end
            `AWC_OFF_RES_HIGH: begin
            end
            `AWC_OFF_RES_LOW: begin
            end
            // Bound writes only store; they never evaluate the window.
            `AWC_OFF_GT_HIGH: begin
               if (r_q.w_lane0) begin
                  r_d.gt[15:8] = r_q.w_data;
               end
            end
            `AWC_OFF_GT_LOW: begin
               if (r_q.w_lane0) begin
                  r_d.gt[7:0] = r_q.w_data;
               end
            end
            `AWC_OFF_LT_HIGH: begin
               if (r_q.w_lane0) begin
                  r_d.lt[15:8] = r_q.w_data;
               end
            end
            `AWC_OFF_LT_LOW: begin
               if (r_q.w_lane0) begin
                  r_d.lt[7:0] = r_q.w_data;
               end
            end
            `AWC_OFF_IRQ_STAT: begin
               if (r_q.w_lane0 && r_q.w_data[0]) begin
                  r_d.irq_stat = 1'b0;
               end
            end
            `AWC_OFF_IRQ_MASK: begin
               if (r_q.w_lane0) begin
                  r_d.irq_mask = r_q.w_data[0];
               end
            end
            default: begin
               r_d.bresp = `AWC_RESP_SLVERR;
            end
         endcase
      end else if (r_q.bvalid && s_axi_bready) begin
         r_d.bvalid = 1'b0;
      end

      // Writing zero clears the flag; writing one leaves it alone.
      if (flag_clear) begin
         r_d.win_flag = 1'b0;
      end

      // A result landing in the clearing cycle still sets the flags.
      if (cif.done) begin
         r_d.raw_code = cif.code;
         if (window_hit) begin
            r_d.win_flag = 1'b1;
            r_d.irq_stat = 1'b1;
         end
      end

      if (do_read) begin
         r_d.rvalid = 1'b1;
         r_d.rresp  = `AWC_RESP_OKAY;
         r_d.rdata  = 32'h0000_0000;
         case (s_axi_araddr)
            `AWC_OFF_CTRL: begin
               r_d.rdata[`AWC_CTRL_BUSY] = cif.busy;
               r_d.rdata[`AWC_CTRL_LEFT] = r_q.left_just;
               r_d.rdata[`AWC_CTRL_WIN]  = r_q.win_flag;
            end
            `AWC_OFF_SAR_DIV: begin
               r_d.rdata[7:0] = r_q.sar_div;
            end
            `AWC_OFF_RES_HIGH: begin
               r_d.rdata[7:0] = result_word[15:8];
            end
            `AWC_OFF_RES_LOW: begin
               r_d.rdata[7:0] = result_word[7:0];
            end
            `AWC_OFF_GT_HIGH: begin
               r_d.rdata[7:0] = r_q.gt[15:8];
            end
            `AWC_OFF_GT_LOW: begin
               r_d.rdata[7:0] = r_q.gt[7:0];
            end
            `AWC_OFF_LT_HIGH: begin
               r_d.rdata[7:0] = r_q.lt[15:8];
            end
            `AWC_OFF_LT_LOW: begin
               r_d.rdata[7:0] = r_q.lt[7:0];
            end
            `AWC_OFF_IRQ_STAT: begin
               r_d.rdata[0] = r_q.irq_stat;
            end
            `AWC_OFF_IRQ_MASK: begin
               r_d.rdata[0] = r_q.irq_mask;
            end
            default: begin
               r_d.rresp = `AWC_RESP_SLVERR;
            end
         endcase
      end else if (r_q.rvalid && s_axi_rready) begin
         r_d.rvalid = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         r_q         <= '0;
         r_q.gt      <= `AWC_RST_GT;
         r_q.lt      <= `AWC_RST_LT;
         r_q.sar_div <= `AWC_RST_SAR_DIV;
      end else if (ce) begin
         r_q <= r_d;
      end
   end
endmodule // awc_top
`default_nettype wire

//--- verification/awc_chk.sv
// Port-level assertions for the window comparator top module.
`timescale 1ns/1ps
`default_nettype none
module awc_chk (
   // Clock, reset and enable
   input wire logic        aclk,
   input wire logic        aresetn,
   input wire logic        ce,
   // Register bus
   input wire logic [7:0]  s_axi_awaddr,
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0]  s_axi_wstrb,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic [7:0]  s_axi_araddr,
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Interrupt
   input wire logic        irq
);
   logic wt;
   logic at;
   assign wt = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   assign at = s_axi_arvalid && s_axi_arready;
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn || !ce);
   a_write_busy: assert property (wt |=>
      !s_axi_awready && !s_axi_wready)
      else $error("write channels not refused while busy");
   a_write_answer: assert property (wt |-> ##[1:2] s_axi_bvalid)
      else $error("write response late");
   a_read_answer: assert property (at |=> s_axi_rvalid)
      else $error("read data late");
   a_read_once: assert property (s_axi_rvalid && s_axi_rready
      |=> !s_axi_rvalid)
      else $error("read data repeated");
   a_wr_unmapped: assert property (wt && s_axi_awaddr > 8'h24 |->
      ##[1:2] (s_axi_bvalid && s_axi_bresp == 2'h2))
      else $error("unmapped write not refused");
   a_rd_unmapped: assert property (at && s_axi_araddr > 8'h24 |=>
      s_axi_rresp == 2'h2)
      else $error("unmapped read not refused");
   a_mask_off: assert property (wt && s_axi_awaddr == 8'h24 && s_axi_wstrb[0]
      && !s_axi_wdata[0] |-> ##2 !irq)
      else $error("masked interrupt still high");
   a_irq_fall: assert property ($fell(irq) && $past(aresetn)
      |-> s_axi_bvalid)
      else $error("interrupt dropped without a write");
endmodule // awc_chk
bind awc_top awc_chk i_awc_chk (.*);
`default_nettype wire

//--- verification/tb.sv
// Self-checking bench for the window comparator.
`timescale 1ns/1ps
`default_nettype none
module tb;
   logic        aclk, aresetn, ce, irq;
   logic [11:0] sample_code;
   logic [7:0]  s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rv;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready;
   logic [45:0] e;
   logic [15:0] r;
   int          mismatches = 0, tests_run = 0, cyc = 0, n0, n1;
   logic [45:0] tbl [12] = '{
      {16'h0100, 16'h0200, 1'b0, 12'h100, 1'b0},
      {16'h0100, 16'h0200, 1'b0, 12'h101, 1'b1},
      {16'h0100, 16'h0200, 1'b0, 12'h1ff, 1'b1},
      {16'h0100, 16'h0200, 1'b0, 12'h200, 1'b0},
      {16'h0200, 16'h0100, 1'b0, 12'h0ff, 1'b1},
      {16'h0200, 16'h0100, 1'b0, 12'h100, 1'b0},
      {16'h0200, 16'h0100, 1'b0, 12'h200, 1'b0},
      {16'h0200, 16'h0100, 1'b0, 12'h201, 1'b1},
      {16'h1000, 16'h2000, 1'b1, 12'h101, 1'b1},
      {16'h1000, 16'h2000, 1'b1, 12'h100, 1'b0},
      {16'h1000, 16'h2000, 1'b0, 12'h101, 1'b0},
      {16'h0ffe, 16'h0000, 1'b0, 12'hfff, 1'b1}};
   awc_top i_awc_top (.*);
   initial begin
      aclk = 1'b0;
      forever #2 aclk = ~aclk;
   end
   // A hung handshake ends the run here rather than stalling forever.
   always @(posedge aclk) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         mismatches++;
         finish_test();
      end
   end
   task automatic finish_test();
      $display("checks %0d mismatches %0d", tests_run, mismatches);
      if (mismatches == 0 && tests_run > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask
   task automatic chk(string nm, logic [31:0] x, logic [31:0] g);
      tests_run++;
      if (g !== x) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", nm, x, g);
      end
   endtask
   task automatic wr(logic [7:0] a, logic [31:0] d, logic [1:0] rs = 2'h0);
      logic aw, w;
      aw = 1'b0;
      w = 1'b0;
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      while (!(aw && w)) begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) begin
            aw = 1'b1;
            s_axi_awvalid <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w = 1'b1;
            s_axi_wvalid <= 1'b0;
         end
      end
      do @(posedge aclk); while (!s_axi_bvalid);
      chk("bresp", rs, s_axi_bresp);
   endtask
   task automatic rd(logic [7:0] a, logic [1:0] rs = 2'h0);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      do @(posedge aclk); while (!s_axi_arready);
      s_axi_arvalid <= 1'b0;
      do @(posedge aclk); while (!s_axi_rvalid);
      rv = s_axi_rdata;
      chk("rresp", rs, s_axi_rresp);
   endtask
   task automatic rc(string nm, logic [7:0] a, logic [31:0] x);
      rd(a);
      chk(nm, x, rv);
   endtask
   task automatic bounds(logic [15:0] g, logic [15:0] l);
      wr(8'h10, 32'(g[15:8]));
      wr(8'h14, 32'(g[7:0]));
      wr(8'h18, 32'(l[15:8]));
      wr(8'h1c, 32'(l[7:0]));
   endtask
   // Start keeps the flag bit at one so that starting never clears it.
   task automatic conv(logic lj);
      wr(8'h00, 32'({1'b1, lj, 2'b01}));
      do rd(8'h00); while (!rv[1]);
      do rd(8'h00); while (rv[1]);
   endtask
   task automatic tconv(output int n);
      n = 0;
      wr(8'h00, 32'h9);
      while (!irq) begin
         @(posedge aclk);
         n++;
      end
   endtask
   initial begin
      {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_arvalid} <= 4'h0;
      {ce, s_axi_bready, s_axi_rready} <= 3'h7;
      {sample_code, s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= 60'h0;
      s_axi_wstrb <= 4'hf;
      repeat (6) @(posedge aclk);
      aresetn <= 1'b1;
      @(posedge aclk);
      rc("gt high", 8'h10, 32'hff);
      rc("gt low", 8'h14, 32'hff);
      rc("lt high", 8'h18, 32'h0);
      rc("lt low", 8'h1c, 32'h0);
      rc("ctrl", 8'h00, 32'h0);
      chk("irq", 32'h0, 32'(irq));
      $display("test reset done");
      wr(8'h28, 32'h1, 2'h2);
      rd(8'h28, 2'h2);
      $display("test unmapped done");
      foreach (tbl[i]) begin
         e = tbl[i];
         bounds(e[45:30], e[29:14]);
         wr(8'h00, 32'({e[13], 2'b00}));
         wr(8'h20, 32'h1);
         sample_code <= e[12:1];
         conv(e[13]);
         r = e[13] ? {e[12:1], 4'h0} : {4'h0, e[12:1]};
         rd(8'h00);
         chk("window flag", 32'(e[0]), 32'(rv[3]));
         rc("result high", 8'h08, 32'(r[15:8]));
         rc("result low", 8'h0c, 32'(r[7:0]));
         rc("irq status", 8'h20, 32'(e[0]));
      end
      $display("test window done");
      sample_code <= 12'h000;
      conv(1'b0);
      rc("ctrl sticky", 8'h00, 32'h8);
      wr(8'h00, 32'h0);
      wr(8'h20, 32'h1);
      bounds(16'hffff, 16'h0001);
      rc("ctrl no eval", 8'h00, 32'h0);
      rc("status no eval", 8'h20, 32'h0);
      conv(1'b0);
      wr(8'h00, 32'h8);
      rc("ctrl set", 8'h00, 32'h8);
      $display("test sticky done");
      wr(8'h24, 32'h1);
      chk("irq on", 32'h1, 32'(irq));
      rc("mask", 8'h24, 32'h1);
      wr(8'h24, 32'h0);
      chk("irq masked", 32'h0, 32'(irq));
      wr(8'h24, 32'h1);
      wr(8'h20, 32'h1);
      chk("irq cleared", 32'h0, 32'(irq));
      s_axi_wstrb <= 4'he;
      wr(8'h14, 32'h55);
      s_axi_wstrb <= 4'hf;
      rc("strobe off", 8'h14, 32'hff);
      $display("test interrupt done");
      tconv(n0);
      wr(8'h20, 32'h1);
      wr(8'h04, 32'h2);
      rc("divider", 8'h04, 32'h2);
      tconv(n1);
      chk("conversion length", 32'd26, 32'(n1 - n0));
      // A frozen clock enable must stretch the conversion edge for edge.
      wr(8'h20, 32'h1);
      wr(8'h00, 32'h9);
      ce <= 1'b0;
      repeat (10) @(posedge aclk);
      ce <= 1'b1;
      n0 = 10;
      while (!irq) begin
         @(posedge aclk);
         n0++;
      end
      chk("frozen length", 32'(n1 + 10), 32'(n0));
      $display("test timing done");
      finish_test();
   end
endmodule // tb
`default_nettype wire
